/* logic/pic_map.vh */
// register map, field positions and reset values of the interrupt controller
// assumes: included by bare name into the controller design files
`ifndef PIC_MAP_VH
`define PIC_MAP_VH

// ============================================================
// register indices; byte address is four times the index
`define PIC_IDX_EDGE     16'h0fcd
`define PIC_IDX_CTRL     16'h0fcf
`define PIC_IDX_REQ      16'h0fc0
`define PIC_IDX_LEVEL    16'h0fc1
`define PIC_IDX_ISTAT    16'h0fc2
`define PIC_IDX_IMASK    16'h0fc3
`define PIC_IDX_VECT     16'h0fc4

// ============================================================
// field positions
`define PIC_CTRL_GIE     7
`define PIC_ST_LATCH     0
`define PIC_ST_ACK       1
`define PIC_ST_TRAP      2
`define PIC_WDT_SRC      0

// ============================================================
// reset values and level codes
`define PIC_EDGE_RST     8'h00
`define PIC_CTRL_RST     8'h00
`define PIC_LEVEL_RST    32'h0000_0000
`define PIC_ST_RST       3'h0
`define PIC_LVL_OFF      2'h0
`define PIC_LVL_TOP      2'h3
`define PIC_LVL_LOW      2'h1

`endif

/* logic/pic_prio_pick.v */
// fixed-order three-level priority picker for pending requests
// assumes: inputs come from registers on the same clock; output is
// combinational and is registered by the caller
`timescale 1ns/100ps
`include "pic_map.vh"

module pic_prio_pick
#(
    parameter NSRC = 17
)
(
    // candidates and their levels, two bits per source
    input  wire [NSRC-1:0]   pending,
    input  wire [2*NSRC-1:0] levels,
    // result
    output reg               found,
    output reg  [4:0]        winner
);

    integer lvl;
    integer i;

    // ============================================================
    // search top level first, lowest index first inside a level
    always @*
    begin
        found  = 1'b0;
        winner = 5'h00;
        for (lvl = 3; lvl >= 1; lvl = lvl - 1)
        begin
            for (i = 0; i < NSRC; i = i + 1)
            begin
                if (!found && pending[i] &&
                    levels[2*i +: 2] == lvl[1:0])
                begin
                    found  = 1'b1;
                    winner = i[4:0];
                end
            end
        end
    end

endmodule

/* logic/pic_ctrl.v */
// three-level interrupt controller with apb register access
// assumes: one clock, peripheral pulses and core strobes are synchronous,
// port pins are asynchronous and are synchronised here
`timescale 1ns/100ps
`include "pic_map.vh"

// What this block does
// - ei, return_from_irq_instruction or write one sets enable
// - di, ack, write zero, traps clear enable
// - three priority levels, three most urgent
// - higher level always beats lower level
// - fixed vector order inside one level
// - watchdog request always sits at level three
// - core acknowledge clears the request the picker selects in the ack cycle
// - writing zero clears a pending request
// - edge bit picks falling zero, rising one
// - watchdog request waits for stop recovery end
module pic_ctrl
#(
    parameter NPER = 8,
    parameter NPIN = 8
)
(
    // clock and reset
    input  wire              core_clk,
    input  wire              rst,
    // apb slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [15:0]       paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    // request sources
    input  wire [NPER-1:0]   periphReq,
    input  wire [NPIN-1:0]   portPin,
    input  wire              wdtTimeout,
    input  wire              wdtIrqEnable,
    // core instruction and trap strobes
    input  wire              enableIntsInstr,
    input  wire              disableIntsInstr,
    input  wire              returnFromIrqInstr,
    input  wire              trapExec,
    input  wire              illegalTrap,
    input  wire              primOscFail,
    input  wire              wdtOscFail,
    input  wire              stopRecovering,
    // core request port
    input  wire              coreAck,
    output reg               irqValid,
    output reg  [4:0]        irqVector,
    output reg               irqOut
);

    // source 0 is the watchdog, then the peripherals, then the port pins
    localparam NSRC = NPER + NPIN + 1;
    localparam PINLO = NPER + 1;

    // ============================================================
    // state
    reg  [NPIN-1:0]      pinMeta;
    reg  [NPIN-1:0]      pinSync;
    reg  [NPIN-1:0]      pinLast;
    reg  [7:0]           edgeSel;
    reg                  globalEnable;
    reg  [NSRC-1:0]      reqPend;
    reg  [2*NSRC-3:0]    levelCfg;
    reg  [2:0]           intStat;
    reg  [2:0]           intMask;
    // next_ values are built in the combinational blocks further down
    reg  [NSRC-1:0]      next_reqPend;
    reg                  next_globalEnable;
    reg  [2:0]           next_intStat;
    reg  [31:0]          readMux;
    reg                  addrHit;

    wire [NSRC-1:0]      reqRaise;
    wire [NPIN-1:0]      pinEdge;
    wire [2*NSRC-1:0]    allLevels;
    wire [NSRC-1:0]      candidates;
    wire                 pickFound;
    wire [4:0]           pickIdx;
    wire                 setupPhase;
    wire                 wrAccess;
    wire                 anyTrap;
    wire                 ackTake;
    wire                 wrEdge;
    wire                 wrCtrl;
    wire                 wrReq;
    wire                 wrLevel;
    wire                 wrStat;
    wire                 wrMask;

    // ============================================================
    // helpers
    // byte address of a register index; indices count words
    function [15:0] byteAddr;
        input [15:0] idx;
        begin
            byteAddr = {idx[13:0], 2'b00};
        end
    endfunction

    function isReg;
        input [15:0] addr;
        input [15:0] idx;
        begin
            isReg = (addr == byteAddr(idx));
        end
    endfunction

    // ============================================================
    // port pin synchroniser; the first stage feeds only the second
    // pins are asynchronous: two stages keep metastability away from
    // the edge logic, at the price of two cycles of latency
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pinMeta <= {NPIN{1'b0}};
            pinSync <= {NPIN{1'b0}};
            pinLast <= {NPIN{1'b0}};
        end
        else
        begin
            pinMeta <= portPin;
            pinSync <= pinMeta;
            pinLast <= pinSync;
        end
    end

    // per-pin edge choice from the polarity bits
    // both polarities come from the same two samples, so changing a
    // select bit while its pin rests raises no request
    assign pinEdge = (edgeSel[NPIN-1:0] & pinSync & ~pinLast) |
                     (~edgeSel[NPIN-1:0] & ~pinSync & pinLast);

    // watchdog only raises when configured for interrupt
    assign reqRaise = {pinEdge, periphReq,
                       wdtTimeout & wdtIrqEnable};

    // watchdog level is fixed; others from the level register
    assign allLevels = {levelCfg, `PIC_LVL_TOP};

    // watchdog held back while stop recovery is still running
    assign candidates = reqPend &
        ~({{(NSRC-1){1'b0}}, stopRecovering});

    // combinational picker; its result is only used through registers
    pic_prio_pick
    #(
        .NSRC (NSRC)
    )
    u_pick
    (
        .pending (candidates),
        .levels  (allLevels),
        .found   (pickFound),
        .winner  (pickIdx)
    );

    // ============================================================
    // apb decode
    assign setupPhase = psel & ~penable;
    assign wrAccess   = psel & penable & pready & pwrite;
    assign anyTrap    = trapExec | illegalTrap | primOscFail | wdtOscFail;
    assign ackTake    = coreAck & irqValid;

    // one decoded write strobe per writable register, so a change of the map
    // touches this decode and none of the update logic
    assign wrEdge  = wrAccess & isReg(paddr, `PIC_IDX_EDGE);
    assign wrCtrl  = wrAccess & isReg(paddr, `PIC_IDX_CTRL);
    assign wrReq   = wrAccess & isReg(paddr, `PIC_IDX_REQ);
    assign wrLevel = wrAccess & isReg(paddr, `PIC_IDX_LEVEL);
    assign wrStat  = wrAccess & isReg(paddr, `PIC_IDX_ISTAT);
    assign wrMask  = wrAccess & isReg(paddr, `PIC_IDX_IMASK);

    // read mux and hit check; unmapped addresses answer with an error
    // narrow registers sit in the low bits; upper bits read zero
    always @*
    begin
        readMux = 32'h0000_0000;
        addrHit = 1'b1;
        if (isReg(paddr, `PIC_IDX_EDGE))
            readMux[7:0] = edgeSel;
        else if (isReg(paddr, `PIC_IDX_CTRL))
            readMux[`PIC_CTRL_GIE] = globalEnable;
        else if (isReg(paddr, `PIC_IDX_REQ))
            readMux[NSRC-1:0] = reqPend;
        else if (isReg(paddr, `PIC_IDX_LEVEL))
            readMux[2*NSRC-3:0] = levelCfg;
        else if (isReg(paddr, `PIC_IDX_ISTAT))
            readMux[2:0] = intStat;
        else if (isReg(paddr, `PIC_IDX_IMASK))
            readMux[2:0] = intMask;
        else if (isReg(paddr, `PIC_IDX_VECT))
            readMux[5:0] = {pickFound, pickIdx};
        else
            addrHit = 1'b0;
    end

    // one wait-free answer: data and ready are set up in the setup cycle
    // read data are captured in the setup cycle, so the access cycle
    // sees a stable word even if a request bit changes under it
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setupPhase;
            pslverr <= setupPhase & ~addrHit;
            if (setupPhase)
                prdata <= pwrite ? 32'h0000_0000 : readMux;
        end
    end

    // ============================================================
    // request bits: new pulses win over any clear in the same cycle
    // a write clears only the bits written as zero, so a pulse that
    // arrives in the access cycle of the write is never lost by the clear
    always @*
    begin
        next_reqPend = reqPend;
        if (ackTake)
            next_reqPend[pickIdx] = 1'b0;
        if (wrReq)
            next_reqPend = next_reqPend & pwdata[NSRC-1:0];
        next_reqPend = next_reqPend | reqRaise;
    end

    // global enable: hardware clears first, then instructions, then writes
    // a trap in the cycle of an enable write must still leave it off
    always @*
    begin
        next_globalEnable = globalEnable;
        if (wrCtrl)
            next_globalEnable = pwdata[`PIC_CTRL_GIE];
        if (enableIntsInstr || returnFromIrqInstr)
            next_globalEnable = 1'b1;
        if (disableIntsInstr || ackTake || anyTrap)
            next_globalEnable = 1'b0;
    end

    // sticky event bits, write one to clear, a new event wins
    // the status feeds only the level output; the core port works from
    // the request bits, so a mask here never hides a pending request
    always @*
    begin
        next_intStat = intStat;
        if (wrStat)
            next_intStat = intStat & ~pwdata[2:0];
        if (|reqRaise)
            next_intStat[`PIC_ST_LATCH] = 1'b1;
        if (ackTake)
            next_intStat[`PIC_ST_ACK] = 1'b1;
        if (anyTrap)
            next_intStat[`PIC_ST_TRAP] = 1'b1;
    end

    // ============================================================
    // register file and delivery to the core
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            edgeSel      <= `PIC_EDGE_RST;
            globalEnable <= 1'b0;
            reqPend      <= {NSRC{1'b0}};
            levelCfg     <= `PIC_LEVEL_RST;
            intStat      <= `PIC_ST_RST;
            intMask      <= `PIC_ST_RST;
            irqValid     <= 1'b0;
            irqVector    <= 5'h00;
            irqOut       <= 1'b0;
        end
        else
        begin
            if (wrEdge)
                edgeSel <= pwdata[7:0];
            if (wrLevel)
                levelCfg <= pwdata[2*NSRC-3:0];
            if (wrMask)
                intMask <= pwdata[2:0];
            reqPend      <= next_reqPend;
            globalEnable <= next_globalEnable;
            intStat      <= next_intStat;
            irqOut       <= |(next_intStat & intMask);
            // withdrawn as soon as enable drops; requests stay latched
            // the offer is registered from the current winner, so a
            // pulse latched at one edge is offered one edge later
            irqValid  <= next_globalEnable & pickFound & ~ackTake;
            irqVector <= pickIdx;
        end
    end

endmodule

/* dv/pic_ctrl_chk.sv */
// port checker for the interrupt controller
// assumes: bound into pic_ctrl, one clock domain
`timescale 1ns/100ps
`include "pic_map.vh"
module pic_ctrl_chk
#(
    parameter NPER = 8,
    parameter NPIN = 8
)
(
    // clock, reset and apb
    input wire        core_clk,
    input wire        rst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [15:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    // core port and clearing strobes
    input wire        coreAck,
    input wire        irqValid,
    input wire        disableIntsInstr,
    input wire        trapExec,
    input wire        illegalTrap,
    input wire        primOscFail,
    input wire        wdtOscFail
);
    // ========================================================
    // decode
    wire [15:0] idx = paddr >> 2;
    wire mapped = paddr[1:0] == 2'h0 && (idx == `PIC_IDX_EDGE
        || idx == `PIC_IDX_CTRL || (idx >= `PIC_IDX_REQ
        && idx <= `PIC_IDX_VECT));
    wire anyClr = disableIntsInstr | trapExec | illegalTrap
        | primOscFail | wdtOscFail;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence apbSetup;
        psel && !penable;
    endsequence
    sequence coreTake;
        coreAck && irqValid;
    endsequence
    a_setup_ready: assert property (apbSetup |=> pready && penable)
        else $error("setup not answered next cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_unmapped_err: assert property (pready && !mapped |-> pslverr)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (pready && mapped |-> !pslverr)
        else $error("mapped access refused");
    a_ctrl_rsvd: assert property (
        pready && !pwrite && idx == `PIC_IDX_CTRL |-> prdata[6:0] == 7'h00)
        else $error("reserved control bits not zero");
    a_ack_drops: assert property (coreTake |=> !irqValid)
        else $error("offer stays after acknowledge");
    a_clear_blocks: assert property (anyClr |=> !irqValid)
        else $error("offer stays after disable");
    a_reset_quiet: assert property ($past(rst) |-> !irqValid)
        else $error("offer right after reset");
endmodule
bind pic_ctrl pic_ctrl_chk #(.NPER(NPER), .NPIN(NPIN)) chkU (.core_clk,
    .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .coreAck, .irqValid, .disableIntsInstr, .trapExec, .illegalTrap,
    .primOscFail, .wdtOscFail);

/* dv/pic_core_model.sv */
// behavioural core that takes offered interrupt requests
// assumes: same clock as the controller
`timescale 1ns/100ps
module pic_core_model
(
    // clock and reset
    input  wire       core_clk,
    input  wire       rst,
    // request port and pacing
    input  wire       irqValid,
    input  wire [1:0] ackDelay,
    output reg        coreAck
);
    // ========================================================
    // acknowledge
    reg [1:0] waitCnt;
    wire      offered = irqValid && !coreAck;
    // a slow core makes the controller hold its offer for a while
    always @(posedge core_clk or posedge rst)
        if (rst)
            {coreAck, waitCnt} <= 3'h0;
        else
        begin
            coreAck <= offered && waitCnt == ackDelay;
            waitCnt <= (offered && waitCnt != ackDelay) ?
                waitCnt + 2'h1 : 2'h0;
        end
endmodule

/* dv/test_priority_interrupt_controller.sv */
// self-checking bench for the interrupt controller
// assumes: controller, checker and core model compiled first
`timescale 1ns/100ps
`include "pic_map.vh"
module test_priority_interrupt_controller;
    // ========================================================
    // signals
    localparam [15:0] aEdge = `PIC_IDX_EDGE << 2;
    localparam [15:0] aCtrl = `PIC_IDX_CTRL << 2;
    localparam [15:0] aReq = `PIC_IDX_REQ << 2;
    localparam [15:0] aLvl = `PIC_IDX_LEVEL << 2;
    localparam [15:0] aStat = `PIC_IDX_ISTAT << 2;
    localparam [15:0] aMask = `PIC_IDX_IMASK << 2;
    localparam [15:0] aVect = `PIC_IDX_VECT << 2;
    reg         core_clk, rst, psel, penable, pwrite, rerr;
    reg  [15:0] paddr;
    reg  [31:0] pwdata, rdat, lvl;
    reg  [7:0]  periphReq, portPin, pv, e;
    reg  [4:0]  clr;
    reg  [1:0]  st, ackDelay;
    reg         wdtTimeout, wdtIrqEnable, stopRecovering;
    reg  [16:0] req;
    reg  [5:0]  ex;
    wire [31:0] prdata;
    wire        pready, pslverr, coreAck, irqValid, irqOut;
    wire [4:0]  irqVector;
    integer     nErrors, testsRun, i, k;
    pic_ctrl dut_u (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .periphReq, .portPin,
        .wdtTimeout, .wdtIrqEnable, .enableIntsInstr(st[0]),
        .returnFromIrqInstr(st[1]), .disableIntsInstr(clr[0]),
        .trapExec(clr[1]), .illegalTrap(clr[2]), .primOscFail(clr[3]),
        .wdtOscFail(clr[4]), .stopRecovering, .coreAck, .irqValid,
        .irqVector, .irqOut);
    pic_core_model coreU (.core_clk, .rst, .irqValid, .ackDelay, .coreAck);
    // expected winner: top level first, lowest index inside a level
    function [5:0] pick(input [16:0] r, input [31:0] lv);
        integer l, s;
        begin
            pick = 6'h00;
            for (l = 1; l <= 3; l = l + 1)
                for (s = 16; s >= 0; s = s - 1)
                    if (r[s] && (s == 0 ? 3 : lv[2*s-2 +: 2]) == l)
                        pick = {1'b1, s[4:0]};
        end
    endfunction
    task chk(input string what, input [31:0] ev, input [31:0] gv);
        begin
            testsRun = testsRun + 1;
            if (gv !== ev)
            begin
                $display("[FAIL] %s exp %h got %h", what, ev, gv);
                nErrors = nErrors + 1;
            end
        end
    endtask
    // one apb transfer, request held until pready is sampled
    task apb(input w, input [15:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
            @(posedge core_clk);
            penable <= 1'b1;
            @(posedge core_clk);
            while (pready !== 1'b1)
                @(posedge core_clk);
            {rdat, rerr} = {prdata, pslverr};
            {psel, penable} <= 2'b00;
        end
    endtask
    task rd(input string what, input [15:0] a, input [31:0] ev);
        begin
            apb(1'b0, a, 32'h0);
            chk(what, ev, rdat);
        end
    endtask
    // wait, bounded, for the core to take the offer
    task take(input [4:0] ev);
        begin
            for (k = 0; k < 30 && coreAck !== 1'b1; k = k + 1)
                @(posedge core_clk);
            chk("coreAck", 1, coreAck);
            chk("irqVector", ev, irqVector);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge core_clk);
    endtask
    task testDone;
        begin
            $display("checks %0d errors %0d", testsRun, nErrors);
            if (nErrors == 0 && testsRun > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // ========================================================
    // clock and watchdog
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial
    begin
        #100000;
        nErrors = nErrors + 1;
        testDone;
    end
    // ========================================================
    // main sequence
    initial
    begin
        {rst, psel, penable} = 3'h4;
        {pwrite, paddr, pwdata} = 49'h0;
        {periphReq, portPin, clr, st, ackDelay} = 25'h0;
        {wdtTimeout, wdtIrqEnable, stopRecovering} = 3'b010;
        {nErrors, testsRun, i} = {32'h0, 32'h0, $urandom(93)};
        tick(12);
        rst <= 1'b0;
        rd("edge reset", aEdge, 0);
        rd("ctrl reset", aCtrl, 0);
        apb(1'b1, aCtrl, 32'h80);
        rd("ctrl write", aCtrl, 32'h80);
        apb(1'b0, 16'h3f14, 0);
        chk("pslverr", 1, rerr);
        apb(1'b1, aCtrl, 0);
        rd("ctrl zero", aCtrl, 0);
        for (i = 0; i < 5; i = i + 1)
        begin
            st <= 2'h1 << (i % 2);
            @(posedge core_clk);
            st <= 2'h0;
            rd("ctrl set", aCtrl, 32'h80);
            clr <= 5'h01 << i;
            @(posedge core_clk);
            clr <= 5'h00;
            rd("ctrl clr", aCtrl, 0);
        end
        // random levels and requests; all-top and all-off first
        for (i = 0; i < 24; i = i + 1)
        begin
            lvl = i == 0 ? 32'hffffffff : i == 1 ? 32'h0 : $urandom;
            pv = $urandom;
            pv[i % 8] = 1'b1;
            ackDelay <= $urandom;
            req = {8'h00, pv, 1'b0};
            ex = pick(req, lvl);
            apb(1'b1, aLvl, lvl);
            periphReq <= pv;
            @(posedge core_clk);
            periphReq <= 8'h00;
            rd("vect", aVect, ex);
            rd("req held", aReq, req);
            apb(1'b1, aCtrl, 32'h80);
            if (ex[5])
            begin
                take(ex[4:0]);
                tick(2);
                rd("req ack", aReq, req & ~(17'h1 << ex[4:0]));
                rd("ctrl ack", aCtrl, 0);
            end
            apb(1'b1, aReq, 0);
            rd("req clear", aReq, 0);
            apb(1'b1, aCtrl, 0);
        end
        // watchdog outranks level one and waits out stop recovery
        apb(1'b1, aLvl, 32'h55555555);
        {wdtTimeout, periphReq} <= 9'h180;
        @(posedge core_clk);
        {wdtTimeout, periphReq} <= 9'h0;
        rd("wdt vect", aVect, 32'h20);
        // during stop recovery the level one peripheral goes first
        stopRecovering <= 1'b1;
        rd("stop vect", aVect, 32'h28);
        apb(1'b1, aCtrl, 32'h80);
        take(5'h08);
        apb(1'b1, aCtrl, 32'h80);
        tick(4);
        chk("stop hold", 0, irqValid);
        stopRecovering <= 1'b0;
        take(5'h00);
        apb(1'b1, aReq, 0);
        // pin edges per edge select bit
        e = $urandom;
        apb(1'b1, aEdge, e);
        rd("edge rw", aEdge, e);
        portPin <= 8'hff;
        tick(6);
        rd("rise", aReq, {e, 9'h0});
        portPin <= 8'h00;
        tick(6);
        rd("fall", aReq, 32'h1fe00);
        // status, mask and level output
        apb(1'b1, aStat, 7);
        apb(1'b1, aMask, 1);
        periphReq <= 8'h01;
        @(posedge core_clk);
        periphReq <= 8'h00;
        tick(3);
        chk("irq raised", 1, irqOut);
        apb(1'b1, aMask, 0);
        tick(2);
        chk("irq masked", 0, irqOut);
        apb(1'b1, aStat, 1);
        apb(1'b1, aMask, 1);
        tick(2);
        chk("irq cleared", 0, irqOut);
        testDone;
    end
endmodule
